// >>> verilog/vie_encoder.sv
`timescale 1ns/1ps
`include "vie_defs.svh"

module vie_encoder (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic                clk_en,
  // Failure report from execution and entry checks
  input  wire logic                fail_valid,
  input  wire vie_pkg::vie_op_e    fail_op,
  input  wire vie_pkg::vie_cond_s  fail_cond,
  input  wire logic                working_ptr_valid,
  // Result toward flags and the guest control structure
  output vie_pkg::vie_result_s     result,
  output logic                     result_valid,
  output vie_pkg::vie_code_t       instr_error_field
);
  import vie_pkg::*;

  function automatic vie_code_t entry_code(input vie_cond_s c);
    // Fixed priority; any applicable cause is acceptable to software
    if (c.ss_blocked)
      return `VIE_CODE_ENTRY_SS_BLOCK;
    else if (c.exec_ptr_bad)
      return `VIE_CODE_EXEC_PTR;
    else if (c.exec_not_launched)
      return `VIE_CODE_EXEC_NLAUNCH;
    else if (c.exec_not_enter)
      return `VIE_CODE_EXEC_NOT_ENTER;
    else if (c.ctrl_bad && c.mgmt_return)
      return `VIE_CODE_MGMT_EXEC_CTRL;
    else if (c.ctrl_bad)
      return `VIE_CODE_ENTRY_CTRL;
    else if (c.host_bad)
      return `VIE_CODE_ENTRY_HOST;
    else
      return `VIE_CODE_NONE;
  endfunction

  function automatic vie_code_t encode(input vie_op_e op, input vie_cond_s c);
    vie_code_t r;
    r = `VIE_CODE_NONE;
    case (op)
      VIE_OP_CALL: begin
        if (c.dual_activate && c.not_clear)
          r = `VIE_CODE_CALL_NCLEAR;
        else if (c.dual_activate && c.seg_rev_bad)
          r = `VIE_CODE_CALL_SEG_REV;
        else if (c.dual_activate && c.features_bad)
          r = `VIE_CODE_CALL_FEATURES;
        else if (c.exit_ctrl_bad)
          r = `VIE_CODE_CALL_EXIT_CTRL;
        else if (c.in_root)
          r = `VIE_CODE_CALL_ROOT;
      end
      VIE_OP_CLEAR: begin
        if (c.bad_addr)
          r = `VIE_CODE_CLR_BAD_ADDR;
        else if (c.is_enter_ptr)
          r = `VIE_CODE_CLR_ENTER_PTR;
      end
      VIE_OP_LAUNCH: begin
        if (c.not_clear)
          r = `VIE_CODE_LAUNCH_NCLEAR;
        else
          r = entry_code(c);
      end
      VIE_OP_RESUME: begin
        if (c.reentered)
          r = `VIE_CODE_RESUME_REENTER;
        else if (c.not_launched)
          r = `VIE_CODE_RESUME_NLAUNCH;
        else
          r = entry_code(c);
      end
      VIE_OP_PLOAD: begin
        if (c.bad_addr)
          r = `VIE_CODE_PLD_BAD_ADDR;
        else if (c.is_enter_ptr)
          r = `VIE_CODE_PLD_ENTER_PTR;
        else if (c.rev_mismatch)
          r = `VIE_CODE_PLD_REVISION;
      end
      VIE_OP_FREAD: begin
        if (c.field_unsup)
          r = `VIE_CODE_FIELD_UNSUP;
      end
      VIE_OP_FWRITE: begin
        if (c.field_unsup)
          r = `VIE_CODE_FIELD_UNSUP;
        else if (c.field_rdonly)
          r = `VIE_CODE_FIELD_RDONLY;
      end
      VIE_OP_EXIT: begin
        if (c.dual_active)
          r = `VIE_CODE_EXIT_DUAL;
      end
      VIE_OP_ENTER: begin
        if (c.in_root)
          r = `VIE_CODE_ENTER_ROOT;
      end
      VIE_OP_INVTR, VIE_OP_INVTAG: begin
        if (c.inv_operand_bad)
          r = `VIE_CODE_INVALIDATE_OP;
      end
      default: r = `VIE_CODE_NONE;
    endcase
    return r;
  endfunction

  // Decode
  wire vie_code_t code_sel;
  wire logic      code_hit;
  wire logic      take;
  wire logic      ptr_fail;
  wire logic      code_fail;

  assign code_sel  = encode(fail_op, fail_cond);
  // Report with a valid working pointer and no matching cause is dropped, never coded as 0
  assign code_hit  = (code_sel != `VIE_CODE_NONE);
  assign take      = clk_en && fail_valid;
  assign ptr_fail  = take && !working_ptr_valid;
  assign code_fail = take && working_ptr_valid && code_hit;

  vie_result_s result_r;
  vie_result_s result_nxt;
  logic        valid_r;
  vie_code_t   field_r;

  always_comb begin
    result_nxt = '0;
    if (ptr_fail) begin
      result_nxt.carry_flag = 1'b1;
    end else if (code_fail) begin
      result_nxt.zero_flag = 1'b1;
      result_nxt.code_wr   = 1'b1;
      result_nxt.code      = code_sel;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_r <= '0;
      valid_r  <= 1'b0;
      field_r  <= `VIE_CODE_NONE;
    end else if (clk_en) begin
      result_r <= result_nxt;
      valid_r  <= ptr_fail || code_fail;
      if (code_fail)
        field_r <= code_sel;
    end
  end

  assign result            = result_r;
  assign result_valid      = valid_r;
  assign instr_error_field = field_r;

  // Entry check gates, read only by the checks below
  wire logic entry_gate;
  wire logic entry_early;
  wire logic entry_late;

  assign entry_gate  = ((fail_op == VIE_OP_LAUNCH) && !fail_cond.not_clear)
                    || ((fail_op == VIE_OP_RESUME) && !fail_cond.reentered && !fail_cond.not_launched);
  assign entry_early = fail_cond.ss_blocked || fail_cond.exec_ptr_bad
                    || fail_cond.exec_not_launched || fail_cond.exec_not_enter;
  assign entry_late  = code_fail && entry_gate && !entry_early;

  // Checks
  flags_exclusive_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !(result.carry_flag && result.zero_flag))
    else $error("carry and zero both set");
  carry_no_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && fail_valid && !working_ptr_valid |=> result.carry_flag && !result.code_wr
      && $stable(instr_error_field)) else $error("invalid pointer wrote a code");
  zero_writes_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && code_fail |=> result.zero_flag && result.code_wr
      && instr_error_field == $past(code_sel)) else $error("code not stored");
  dropped_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && working_ptr_valid && !code_hit |=> !result_valid && $stable(instr_error_field))
    else $error("report without cause was not dropped");
  no_unassigned_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    result.code_wr |-> !(result.code inside {5'h00, 5'h0E, 5'h15, 5'h1B}) && result.code <= 5'h1C)
    else $error("unassigned code produced");

  // A stall may hold a result for many cycles, so only enabled cycles with no coded or pointer failure must clear it
  pulse_once_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && !fail_valid |=> !result_valid)
    else $error("result without report");
  hold_on_stall_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !clk_en |=> $stable(result) && $stable(result_valid) && $stable(instr_error_field))
    else $error("state moved while clock enable low");

  call_root_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_CALL && fail_cond.in_root && !fail_cond.dual_activate
      && !fail_cond.exit_ctrl_bad |=> result.code == `VIE_CODE_CALL_ROOT)
    else $error("call in root not code 1");
  call_nclear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_CALL && fail_cond.dual_activate && fail_cond.not_clear
      |=> result.code == `VIE_CODE_CALL_NCLEAR)
    else $error("dual activation non-clear not code 19");
  call_segrev_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_CALL && fail_cond.dual_activate && !fail_cond.not_clear
      && fail_cond.seg_rev_bad |=> result.code == `VIE_CODE_CALL_SEG_REV)
    else $error("segment revision not code 22");
  call_feat_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_CALL && fail_cond.dual_activate && !fail_cond.not_clear
      && !fail_cond.seg_rev_bad && fail_cond.features_bad |=> result.code == `VIE_CODE_CALL_FEATURES)
    else $error("monitor features not code 24");
  call_exit_ctrl_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_CALL && !fail_cond.dual_activate && fail_cond.exit_ctrl_bad
      |=> result.code == `VIE_CODE_CALL_EXIT_CTRL)
    else $error("exit control fields not code 20");

  clear_addr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_CLEAR && fail_cond.bad_addr |=> result.code == `VIE_CODE_CLR_BAD_ADDR)
    else $error("clear bad address not code 2");
  clear_enter_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_CLEAR && !fail_cond.bad_addr && fail_cond.is_enter_ptr
      |=> result.code == `VIE_CODE_CLR_ENTER_PTR)
    else $error("clear enter pointer not code 3");

  launch_nclear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && code_fail && fail_op == VIE_OP_LAUNCH && fail_cond.not_clear |=> result.code == 5'h04)
    else $error("launch non-clear not code 4");
  resume_nlaunch_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_RESUME && !fail_cond.reentered && fail_cond.not_launched
      |=> result.code == `VIE_CODE_RESUME_NLAUNCH)
    else $error("resume non-launched not code 5");
  resume_reenter_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_RESUME && fail_cond.reentered |=> result.code == `VIE_CODE_RESUME_REENTER)
    else $error("resume after re-enter not code 6");

  ss_block_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && entry_gate && fail_cond.ss_blocked |=> result.code == `VIE_CODE_ENTRY_SS_BLOCK)
    else $error("blocked entry not code 26");
  exec_ptr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && entry_gate && !fail_cond.ss_blocked && fail_cond.exec_ptr_bad
      |=> result.code == `VIE_CODE_EXEC_PTR)
    else $error("executive pointer not code 16");
  exec_launch_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && entry_gate && !fail_cond.ss_blocked && !fail_cond.exec_ptr_bad
      && fail_cond.exec_not_launched |=> result.code == `VIE_CODE_EXEC_NLAUNCH)
    else $error("unlaunched executive not code 17");
  exec_enter_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && entry_gate && !fail_cond.ss_blocked && !fail_cond.exec_ptr_bad
      && !fail_cond.exec_not_launched && fail_cond.exec_not_enter |=> result.code == `VIE_CODE_EXEC_NOT_ENTER)
    else $error("executive pointer mismatch not code 18");
  mgmt_ctrl_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    entry_late && fail_cond.ctrl_bad && fail_cond.mgmt_return |=> result.code == `VIE_CODE_MGMT_EXEC_CTRL)
    else $error("management return entry not code 25");
  entry_ctrl_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    entry_late && fail_cond.ctrl_bad && !fail_cond.mgmt_return |=> result.code == `VIE_CODE_ENTRY_CTRL)
    else $error("entry control fields not code 7");
  entry_host_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    entry_late && !fail_cond.ctrl_bad && fail_cond.host_bad |=> result.code == `VIE_CODE_ENTRY_HOST)
    else $error("entry host fields not code 8");
  entry_any_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && entry_gate |=> result.code inside {`VIE_CODE_ENTRY_CTRL, `VIE_CODE_ENTRY_HOST,
      `VIE_CODE_EXEC_PTR, `VIE_CODE_EXEC_NLAUNCH, `VIE_CODE_EXEC_NOT_ENTER, `VIE_CODE_MGMT_EXEC_CTRL,
      `VIE_CODE_ENTRY_SS_BLOCK}) else $error("entry failure gave a non-entry code");

  pload_addr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_PLOAD && fail_cond.bad_addr |=> result.code == `VIE_CODE_PLD_BAD_ADDR)
    else $error("pointer load bad address not code 9");
  pload_enter_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_PLOAD && !fail_cond.bad_addr && fail_cond.is_enter_ptr
      |=> result.code == `VIE_CODE_PLD_ENTER_PTR)
    else $error("pointer load enter pointer not code 10");
  pload_rev_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_PLOAD && !fail_cond.bad_addr && !fail_cond.is_enter_ptr
      && fail_cond.rev_mismatch |=> result.code == `VIE_CODE_PLD_REVISION)
    else $error("pointer load revision not code 11");

  field_unsup_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && (fail_op == VIE_OP_FREAD || fail_op == VIE_OP_FWRITE) && fail_cond.field_unsup
      |=> result.code == `VIE_CODE_FIELD_UNSUP)
    else $error("unsupported field not code 12");
  field_rdonly_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    code_fail && fail_op == VIE_OP_FWRITE && !fail_cond.field_unsup && fail_cond.field_rdonly
      |=> result.code == `VIE_CODE_FIELD_RDONLY)
    else $error("read-only field write not code 13");

  enter_root_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && code_fail && fail_op == VIE_OP_ENTER |=> result.code == 5'h0F)
    else $error("enter in root not code 15");
  exit_dual_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && code_fail && fail_op == VIE_OP_EXIT |=> result.code == 5'h17)
    else $error("exit under dual monitor not code 23");
  invalidate_op_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && code_fail && (fail_op == VIE_OP_INVTR || fail_op == VIE_OP_INVTAG) |=> result.code == 5'h1C)
    else $error("invalidate operand not code 28");

endmodule

// >>> verilog/vie_defs.svh
`ifndef VIE_DEFS_SVH
`define VIE_DEFS_SVH

`define VIE_CODE_W               5
`define VIE_CODE_NONE            5'h00
`define VIE_CODE_CALL_ROOT       5'h01
`define VIE_CODE_CLR_BAD_ADDR    5'h02
`define VIE_CODE_CLR_ENTER_PTR   5'h03
`define VIE_CODE_LAUNCH_NCLEAR   5'h04
`define VIE_CODE_RESUME_NLAUNCH  5'h05
`define VIE_CODE_RESUME_REENTER  5'h06
`define VIE_CODE_ENTRY_CTRL      5'h07
`define VIE_CODE_ENTRY_HOST      5'h08
`define VIE_CODE_PLD_BAD_ADDR    5'h09
`define VIE_CODE_PLD_ENTER_PTR   5'h0A
`define VIE_CODE_PLD_REVISION    5'h0B
`define VIE_CODE_FIELD_UNSUP     5'h0C
`define VIE_CODE_FIELD_RDONLY    5'h0D
`define VIE_CODE_ENTER_ROOT      5'h0F
`define VIE_CODE_EXEC_PTR        5'h10
`define VIE_CODE_EXEC_NLAUNCH    5'h11
`define VIE_CODE_EXEC_NOT_ENTER  5'h12
`define VIE_CODE_CALL_NCLEAR     5'h13
`define VIE_CODE_CALL_EXIT_CTRL  5'h14
`define VIE_CODE_CALL_SEG_REV    5'h16
`define VIE_CODE_EXIT_DUAL       5'h17
`define VIE_CODE_CALL_FEATURES   5'h18
`define VIE_CODE_MGMT_EXEC_CTRL  5'h19
`define VIE_CODE_ENTRY_SS_BLOCK  5'h1A
`define VIE_CODE_INVALIDATE_OP   5'h1C

`endif

// >>> verilog/vie_pkg.sv
`include "vie_defs.svh"

package vie_pkg;

  typedef logic [`VIE_CODE_W-1:0] vie_code_t;

  typedef enum logic [10:0] {
    VIE_OP_CALL   = 11'h001,
    VIE_OP_CLEAR  = 11'h002,
    VIE_OP_LAUNCH = 11'h004,
    VIE_OP_RESUME = 11'h008,
    VIE_OP_PLOAD  = 11'h010,
    VIE_OP_FREAD  = 11'h020,
    VIE_OP_FWRITE = 11'h040,
    VIE_OP_EXIT   = 11'h080,
    VIE_OP_ENTER  = 11'h100,
    VIE_OP_INVTR  = 11'h200,
    VIE_OP_INVTAG = 11'h400
  } vie_op_e;

  typedef struct packed {
    logic in_root;
    logic bad_addr;
    logic is_enter_ptr;
    logic rev_mismatch;
    logic not_clear;
    logic not_launched;
    logic reentered;
    logic ctrl_bad;
    logic host_bad;
    logic field_unsup;
    logic field_rdonly;
    logic exec_ptr_bad;
    logic exec_not_launched;
    logic exec_not_enter;
    logic dual_activate;
    logic dual_active;
    logic mgmt_return;
    logic ss_blocked;
    logic exit_ctrl_bad;
    logic seg_rev_bad;
    logic features_bad;
    logic inv_operand_bad;
  } vie_cond_s;

  typedef struct packed {
    logic      carry_flag;
    logic      zero_flag;
    logic      code_wr;
    vie_code_t code;
  } vie_result_s;

endpackage

// >>> verification/test_vie_encoder.sv
`timescale 1ns/1ps
module test_vie_encoder;
  import vie_pkg::*;
  logic                ref_clk = 1'b0;
  logic                arst_n  = 1'b0;
  logic                clk_en  = 1'b0;
  logic                fail_valid = 1'b0;
  vie_op_e             fail_op = VIE_OP_CALL;
  vie_cond_s           fail_cond = '0;
  logic                working_ptr_valid = 1'b0;
  vie_result_s         result;
  logic                result_valid;
  vie_code_t           instr_error_field;
  int                  fail_count = 0;
  int                  tests_run  = 0;
  int                  ev, ecf, ezf, ewr, ecode, efield;

  always #4 ref_clk = ~ref_clk;

  vie_encoder i_dut (
    .ref_clk           (ref_clk),
    .arst_n            (arst_n),
    .clk_en            (clk_en),
    .fail_valid        (fail_valid),
    .fail_op           (fail_op),
    .fail_cond         (fail_cond),
    .working_ptr_valid (working_ptr_valid),
    .result            (result),
    .result_valid      (result_valid),
    .instr_error_field (instr_error_field)
  );

  // Reference priorities follow the hand-over choices; entry checks shared by launch and resume
  function automatic int mdl(vie_op_e op, vie_cond_s c);
    int e;
    e = c.ss_blocked ? 26 : c.exec_ptr_bad ? 16 : c.exec_not_launched ? 17 : c.exec_not_enter ? 18 :
        c.ctrl_bad ? (c.mgmt_return ? 25 : 7) : c.host_bad ? 8 : 0;
    case (op)
      VIE_OP_CALL:   return (c.dual_activate && c.not_clear) ? 19 : (c.dual_activate && c.seg_rev_bad) ? 22 :
                            (c.dual_activate && c.features_bad) ? 24 : c.exit_ctrl_bad ? 20 : c.in_root ? 1 : 0;
      VIE_OP_CLEAR:  return c.bad_addr ? 2 : c.is_enter_ptr ? 3 : 0;
      VIE_OP_LAUNCH: return c.not_clear ? 4 : e;
      VIE_OP_RESUME: return c.reentered ? 6 : c.not_launched ? 5 : e;
      VIE_OP_PLOAD:  return c.bad_addr ? 9 : c.is_enter_ptr ? 10 : c.rev_mismatch ? 11 : 0;
      VIE_OP_FREAD:  return c.field_unsup ? 12 : 0;
      VIE_OP_FWRITE: return c.field_unsup ? 12 : c.field_rdonly ? 13 : 0;
      VIE_OP_EXIT:   return c.dual_active ? 23 : 0;
      VIE_OP_ENTER:  return c.in_root ? 15 : 0;
      default:       return c.inv_operand_bad ? 28 : 0;
    endcase
  endfunction

  task automatic chk();
    tests_run++;
    if (result_valid !== ev[0] || result.carry_flag !== ecf[0] || result.zero_flag !== ezf[0] ||
        result.code_wr !== ewr[0] || result.code !== 5'(ecode) ||
        instr_error_field !== 5'(efield)) begin
      fail_count++;
      $display("ERROR %0t result mismatch, expected code %0d field %0d", $time, ecode, efield);
    end
  endtask

  // One cycle: check the answer to the previous request, then present the next one
  task automatic step(logic en, logic fv, vie_op_e op, vie_cond_s c, logic ptr);
    int k;
    @(posedge ref_clk);
    #1;
    chk();
    clk_en = en;
    fail_valid = fv;
    fail_op = op;
    fail_cond = c;
    working_ptr_valid = ptr;
    if (en) begin
      k = mdl(op, c);
      ev = 0; ecf = 0; ezf = 0; ewr = 0; ecode = 0;
      if (fv && !ptr) begin
        ev = 1; ecf = 1;
      end else if (fv && k != 0) begin
        ev = 1; ezf = 1; ewr = 1; ecode = k; efield = k;
      end
    end
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    #1;
    // The answer to the last request is still owed before reset wipes it
    chk();
    fail_valid = 1'b0;
    arst_n = 1'b0;
    ev = 0; ecf = 0; ezf = 0; ewr = 0; ecode = 0; efield = 0;
    #1;
    chk();
    @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
  endtask

  task automatic test_done();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    // Bound far above the run length of about 8330 cycles
    #200us;
    fail_count++;
    $display("ERROR %0t run did not finish", $time);
    test_done();
  end

  initial begin
    vie_cond_s c;
    vie_op_e   op;
    void'($urandom(13));
    ev = 0; ecf = 0; ezf = 0; ewr = 0; ecode = 0; efield = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    // Every op against every single and paired condition bit, back to back
    for (int o = 0; o < 11; o++) begin
      for (int i = 0; i < 22; i++) begin
        for (int j = 0; j < 22; j++) begin
          c = '0;
          c[i] = 1'b1;
          c[j] = 1'b1;
          op = vie_op_e'(11'h001 << o);
          step(1'b1, 1'b1, op, c, 1'b1);
        end
      end
    end
    $display("test cause table done");
    // Random traffic with stalls, idle cycles and invalid working pointers
    for (int n = 0; n < 3000; n++) begin
      c = vie_cond_s'(22'($urandom));
      op = vie_op_e'(11'h001 << ($urandom % 11));
      step(($urandom % 4) != 0, 1'($urandom % 2), op, c, ($urandom % 3) != 0);
      if (n == 1500) begin
        do_reset();
      end
    end
    $display("test random traffic done");
    step(1'b1, 1'b0, VIE_OP_CALL, '0, 1'b1);
    step(1'b1, 1'b0, VIE_OP_CALL, '0, 1'b1);
    test_done();
  end
endmodule
